// ==== rtl/seq_flow_pkg.sv ====
package seq_flow_pkg;
  // Widths of statement indices, operands and warning codes.
  localparam int PC_W       = 16;
  localparam int DATA_W     = 32;
  localparam int CODE_W     = 8;
  localparam int DEPTH_W    = 3;
  localparam int HIST_N     = 10;
  // Block nesting limit across all block kinds.
  localparam logic [DEPTH_W-1:0] MAX_DEPTH = 3'h6;
  // Clock and millisecond tick timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  // Delay limits in milliseconds: 0.001 s to 500,000.000 s.
  localparam logic [31:0] DELAY_MIN_MS = 32'h0000_0001;
  localparam logic [31:0] DELAY_MAX_MS = 32'h1DCD_6500;
  // Largest operand magnitude accepted in a loop condition.
  localparam logic signed [DATA_W-1:0] MAX_NUM = 32'h7FFF_FFFF;
  // Warning code limits and reset values.
  localparam logic [CODE_W-1:0] WARN_NONE = 8'h00;
  localparam logic [CODE_W-1:0] WARN_MAX  = 8'hF2;
  localparam logic              POL_RESET = 1'h0;
  // Saturation value of the elapsed time counter.
  localparam logic [31:0] ELAPSED_MAX = 32'hFFFF_FFFF;

  // Statements that reach the unit.
  typedef enum logic [2:0] {
    OP_DELAY, OP_LOOP_BEGIN, OP_LOOP_END, OP_LOOP_BREAK, OP_BLOCK_OPEN, OP_BLOCK_CLOSE, OP_OTHER
  } stmt_op_t;

  // Comparison operators of a loop condition.
  typedef enum logic [2:0] {
    CMP_EQ, CMP_NE, CMP_LT, CMP_LE, CMP_GT, CMP_GE
  } cmp_op_t;
endpackage

// ==== rtl/ms_tick_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
// Millisecond prescaler plus a down counter for sequence delays.
module ms_tick_timer #(
  parameter int TICK_CYCLES = seq_flow_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [31:0] load_ms,
  output logic             tick,
  output logic             expired
);
  logic [31:0] pre;        // Cycles within the current millisecond.
  logic [31:0] remain;     // Milliseconds still to wait.
  logic        running;    // A delay is being counted.
  logic [31:0] next_pre;
  logic [31:0] next_remain;
  logic        next_running;
  logic        next_tick;
  logic        next_expired;

  // The prescaler runs free so elapsed time keeps counting between delays.
  // Only start restarts it, and a delay then waits exactly n whole ticks;
  // restarting the prescaler on start makes the wait exact in milliseconds.
  always_comb begin
    next_pre     = pre + 32'h1;
    next_tick    = 1'b0;
    next_remain  = remain;
    next_running = running;
    next_expired = 1'b0;
    if (start) begin
      next_pre     = 32'h0;
      next_remain  = load_ms;
      next_running = 1'b1;
    end else if (pre == 32'(TICK_CYCLES - 1)) begin
      next_pre  = 32'h0;
      next_tick = 1'b1;
      if (running) begin
        // One tick per millisecond resolves the smallest delay exactly.
        next_remain = remain - 32'h1;
        if (remain == 32'h1) begin
          next_running = 1'b0;
          next_expired = 1'b1;
        end
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre     <= 32'h0;
      remain  <= 32'h0;
      running <= 1'b0;
      tick    <= 1'b0;
      expired <= 1'b0;
    end else begin
      pre     <= next_pre;
      remain  <= next_remain;
      running <= next_running;
      tick    <= next_tick;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sequence_flow_and_warning_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Delay holds execution, 0.001 to 500000 seconds.
// - Variable delay argument is taken in milliseconds.
// - Loop end returns to innermost loop start.
// - True condition continues, false skips past end.
// - Six comparison operators between two operands.
// - Operands bounded by maximum; parentheses required.
// - Condition tested once per iteration only.
// - Break exits loop to statement after end.
// - All blocks nest at most six deep.
// - Query reports code, ten history, elapsed time.
// - Warning history lives in volatile storage only.
// - Current code read-only, 00 to F2, starts 00.
// - Clear returns code to 00 unless warning condition still active, history kept.
// - Polarity 0 normally open, 1 normally closed.
// - New polarity saved, active only after reset.
module sequence_flow_and_warning_unit #(
  parameter int TICK_CYCLES = seq_flow_pkg::TICK_CYCLES
) (
  input  wire logic                                         clk,
  input  wire logic                                         rst_b,
  input  wire logic                                         stmt_valid,
  input  wire seq_flow_pkg::stmt_op_t                       stmt_op,
  input  wire logic [seq_flow_pkg::PC_W-1:0]                stmt_pc,
  input  wire logic [seq_flow_pkg::PC_W-1:0]                stmt_match_pc,
  input  wire logic [31:0]                                  delay_ms,
  input  wire seq_flow_pkg::cmp_op_t                        cmp_op,
  input  wire logic signed [seq_flow_pkg::DATA_W-1:0]       operand_a,
  input  wire logic signed [seq_flow_pkg::DATA_W-1:0]       operand_b,
  input  wire logic                                         cond_paren_ok,
  input  wire logic                                         warn_event,
  input  wire logic [seq_flow_pkg::CODE_W-1:0]              warn_code_in,
  input  wire logic                                         warn_cond_active,
  input  wire logic                                         warning_clear_cmd,
  input  wire logic                                         warning_status_query,
  input  wire logic                                         polarity_write,
  input  wire logic                                         polarity_value,
  input  wire logic                                         polarity_stored,
  output logic                                              stmt_busy,
  output logic                                              flow_done,
  output logic [seq_flow_pkg::PC_W-1:0]                     flow_next_pc,
  output logic                                              flow_error,
  output logic [seq_flow_pkg::DEPTH_W-1:0]                  block_depth,
  output logic [seq_flow_pkg::CODE_W-1:0]                   warn_code,
  output logic                                              report_valid,
  output logic [seq_flow_pkg::CODE_W-1:0]                   report_code,
  output logic [seq_flow_pkg::HIST_N*seq_flow_pkg::CODE_W-1:0] report_history,
  output logic [31:0]                                       report_elapsed_ms,
  output logic                                              polarity_active,
  output logic                                              polarity_pending,
  output logic                                              warning_signal_flag,
  output logic                                              warning_output_assign
);
  localparam int PC_W   = seq_flow_pkg::PC_W;
  localparam int CODE_W = seq_flow_pkg::CODE_W;
  localparam int DW     = seq_flow_pkg::DEPTH_W;
  localparam int NB     = 6;

  typedef enum logic {ST_IDLE, ST_DELAY} flow_state_t;

  flow_state_t      state;              // Idle or holding for a delay.
  flow_state_t      next_state;
  logic [PC_W-1:0]  open_pc [NB];       // Opening statement of each open block.
  logic [PC_W-1:0]  close_pc [NB];      // Closing statement of each open block.
  logic             is_cond [NB];       // Block is a conditional loop.
  logic [PC_W-1:0]  next_open_pc [NB];
  logic [PC_W-1:0]  next_close_pc [NB];
  logic             next_is_cond [NB];
  logic [DW-1:0]    next_block_depth;
  logic             next_flow_done;
  logic [PC_W-1:0]  next_flow_next_pc;
  logic             next_flow_error;
  logic [PC_W-1:0]  delay_pc;           // Statement holding the delay.
  logic [PC_W-1:0]  next_delay_pc;
  logic             timer_start;        // Loads the millisecond timer.
  logic             ms_tick;            // One pulse per millisecond.
  logic             delay_expired;      // Delay has run out.
  logic             cond_true;          // Result of the comparison.
  logic             cond_ok;            // Operands and syntax acceptable.
  logic             cl_found;           // An open conditional loop exists.
  logic [DW-1:0]    cl_idx;             // Innermost conditional loop entry.
  logic             reentry;            // Loop begin already on top.
  logic [DW-1:0]    top;                // Index of the top entry.

  // The shared timer gives both the delay count and the elapsed time base.
  ms_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .start   (timer_start),
    .load_ms (delay_ms),
    .tick    (ms_tick),
    .expired (delay_expired)
  );

  // Comparison of the two operands.
  always_comb begin
    unique case (cmp_op)
      seq_flow_pkg::CMP_EQ: cond_true = (operand_a == operand_b);
      seq_flow_pkg::CMP_NE: cond_true = (operand_a != operand_b);
      seq_flow_pkg::CMP_LT: cond_true = (operand_a <  operand_b);
      seq_flow_pkg::CMP_LE: cond_true = (operand_a <= operand_b);
      seq_flow_pkg::CMP_GT: cond_true = (operand_a >  operand_b);
      seq_flow_pkg::CMP_GE: cond_true = (operand_a >= operand_b);
      default:              cond_true = 1'b0;
    endcase
    // The most negative code has no positive twin, so it is out of range.
    cond_ok = cond_paren_ok && (operand_a >= -seq_flow_pkg::MAX_NUM)
              && (operand_b >= -seq_flow_pkg::MAX_NUM);
  end

  // Find the innermost open conditional loop beneath any other blocks.
  always_comb begin
    cl_found = 1'b0;
    cl_idx   = '0;
    for (int i = 0; i < NB; i++) begin
      if (DW'(i) < block_depth && is_cond[i]) begin
        cl_found = 1'b1;
        cl_idx   = DW'(i);
      end
    end
    top     = block_depth - 3'h1;
    reentry = (block_depth != '0) && is_cond[top] && (open_pc[top] == stmt_pc);
  end

  // Statement handling and block stack.
  always_comb begin
    next_state        = state;
    next_open_pc      = open_pc;
    next_close_pc     = close_pc;
    next_is_cond      = is_cond;
    next_block_depth  = block_depth;
    next_flow_done    = 1'b0;
    next_flow_next_pc = flow_next_pc;
    next_flow_error   = 1'b0;
    next_delay_pc     = delay_pc;
    timer_start       = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (stmt_valid) begin
          next_flow_done    = 1'b1;
          next_flow_next_pc = stmt_pc + 16'h1;
          unique case (stmt_op)
            seq_flow_pkg::OP_DELAY: begin
              // Constants arrive as seconds times 1000, variables as ms.
              if (delay_ms >= seq_flow_pkg::DELAY_MIN_MS && delay_ms <= seq_flow_pkg::DELAY_MAX_MS) begin
                next_flow_done = 1'b0;
                next_state     = ST_DELAY;
                next_delay_pc  = stmt_pc;
                timer_start    = 1'b1;
              end else begin
                next_flow_error = 1'b1;
              end
            end
            seq_flow_pkg::OP_LOOP_BEGIN: begin
              if (!cond_ok) begin
                next_flow_error = 1'b1;
              end else if (cond_true) begin
                // Tested here only; the body never re-checks it.
                if (!reentry) begin
                  if (block_depth == seq_flow_pkg::MAX_DEPTH) begin
                    next_flow_error = 1'b1;
                  end else begin
                    next_open_pc[block_depth]  = stmt_pc;
                    next_close_pc[block_depth] = stmt_match_pc;
                    next_is_cond[block_depth]  = 1'b1;
                    next_block_depth           = block_depth + 3'h1;
                  end
                end
              end else begin
                // False: leave the block past its matching end.
                next_flow_next_pc = stmt_match_pc + 16'h1;
                if (reentry) begin
                  next_block_depth = top;
                end
              end
            end
            seq_flow_pkg::OP_LOOP_END: begin
              if (cl_found) begin
                // Back to the opening statement for re-evaluation.
                next_flow_next_pc = open_pc[cl_idx];
                next_block_depth  = cl_idx + 3'h1;
              end else begin
                // An end with no open loop breaks the pairing.
                next_flow_error = 1'b1;
              end
            end
            seq_flow_pkg::OP_LOOP_BREAK: begin
              if (cl_found) begin
                next_flow_next_pc = close_pc[cl_idx] + 16'h1;
                next_block_depth  = cl_idx;
              end else begin
                next_flow_error = 1'b1;
              end
            end
            seq_flow_pkg::OP_BLOCK_OPEN: begin
              if (block_depth == seq_flow_pkg::MAX_DEPTH) begin
                next_flow_error = 1'b1;
              end else begin
                next_open_pc[block_depth]  = stmt_pc;
                next_close_pc[block_depth] = stmt_match_pc;
                next_is_cond[block_depth]  = 1'b0;
                next_block_depth           = block_depth + 3'h1;
              end
            end
            seq_flow_pkg::OP_BLOCK_CLOSE: begin
              if (block_depth == '0) begin
                next_flow_error = 1'b1;
              end else begin
                next_block_depth = top;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_DELAY: begin
        // Statements are ignored while busy; the sender must wait.
        if (delay_expired) begin
          next_state        = ST_IDLE;
          next_flow_done    = 1'b1;
          next_flow_next_pc = delay_pc + 16'h1;
        end
      end
    endcase
  end

  // Flow registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= ST_IDLE;
      open_pc      <= '{default: '0};
      close_pc     <= '{default: '0};
      is_cond      <= '{default: 1'b0};
      block_depth  <= '0;
      flow_done    <= 1'b0;
      flow_next_pc <= '0;
      flow_error   <= 1'b0;
      delay_pc     <= '0;
      stmt_busy    <= 1'b0;
    end else begin
      state        <= next_state;
      open_pc      <= next_open_pc;
      close_pc     <= next_close_pc;
      is_cond      <= next_is_cond;
      block_depth  <= next_block_depth;
      flow_done    <= next_flow_done;
      flow_next_pc <= next_flow_next_pc;
      flow_error   <= next_flow_error;
      delay_pc     <= next_delay_pc;
      stmt_busy    <= (next_state == ST_DELAY);
    end
  end

  // Warning state. History is plain flip-flops and is lost at reset.
  logic [CODE_W-1:0] hist [seq_flow_pkg::HIST_N];  // Newest at index 0.
  logic [CODE_W-1:0] next_hist [seq_flow_pkg::HIST_N];
  logic [CODE_W-1:0] next_warn_code;
  logic [31:0]       elapsed;                       // ms since latest warning.
  logic [31:0]       next_elapsed;
  logic              warn_take;                     // Legal warning arrives.
  logic [seq_flow_pkg::HIST_N*CODE_W-1:0] hist_flat;
  logic              pol_loaded;                    // Stored level captured.
  logic              next_polarity_active;
  logic              next_polarity_pending;

  // Warning code, history and elapsed time.
  always_comb begin
    warn_take      = warn_event && warn_code_in != seq_flow_pkg::WARN_NONE
                     && warn_code_in <= seq_flow_pkg::WARN_MAX;
    next_warn_code = warn_code;
    next_hist      = hist;
    next_elapsed   = elapsed;
    if (ms_tick && elapsed != seq_flow_pkg::ELAPSED_MAX) begin
      next_elapsed = elapsed + 32'h1;
    end
    // Clear first so a warning in the same cycle overrides it.
    if (warning_clear_cmd && !warn_cond_active) begin
      next_warn_code = seq_flow_pkg::WARN_NONE;
    end
    if (warn_take) begin
      next_warn_code = warn_code_in;
      next_elapsed   = 32'h0;
      for (int i = seq_flow_pkg::HIST_N - 1; i > 0; i--) begin
        next_hist[i] = hist[i-1];
      end
      next_hist[0] = warn_code_in;
    end
    for (int i = 0; i < seq_flow_pkg::HIST_N; i++) begin
      hist_flat[i*CODE_W +: CODE_W] = hist[i];
    end
  end

  // Polarity: the stored level is taken once after reset release.
  always_comb begin
    next_polarity_active  = polarity_active;
    next_polarity_pending = polarity_pending;
    if (!pol_loaded) begin
      next_polarity_active  = polarity_stored;
      next_polarity_pending = polarity_stored;
    end else if (polarity_write) begin
      next_polarity_pending = polarity_value;
    end
  end

  // Warning registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      warn_code             <= seq_flow_pkg::WARN_NONE;
      hist                  <= '{default: seq_flow_pkg::WARN_NONE};
      elapsed               <= '0;
      report_valid          <= 1'b0;
      report_code           <= seq_flow_pkg::WARN_NONE;
      report_history        <= '0;
      report_elapsed_ms     <= '0;
      pol_loaded            <= 1'b0;
      polarity_active       <= seq_flow_pkg::POL_RESET;
      polarity_pending      <= seq_flow_pkg::POL_RESET;
      warning_signal_flag   <= 1'b0;
      warning_output_assign <= 1'b0;
    end else begin
      warn_code         <= next_warn_code;
      hist              <= next_hist;
      elapsed           <= next_elapsed;
      report_valid      <= warning_status_query;
      if (warning_status_query) begin
        report_code       <= warn_code;
        report_history    <= hist_flat;
        report_elapsed_ms <= elapsed;
      end
      pol_loaded            <= 1'b1;
      polarity_active       <= next_polarity_active;
      polarity_pending      <= next_polarity_pending;
      warning_signal_flag   <= (next_warn_code != seq_flow_pkg::WARN_NONE);
      // Level 0 closes on warning; level 1 opens on warning.
      warning_output_assign <= (next_warn_code != seq_flow_pkg::WARN_NONE) ^ next_polarity_active;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_delay_bounds: assert property (stmt_valid && state == ST_IDLE && stmt_op == seq_flow_pkg::OP_DELAY
    && (delay_ms > seq_flow_pkg::DELAY_MAX_MS || delay_ms < seq_flow_pkg::DELAY_MIN_MS)
    |=> flow_error && state == ST_IDLE)
    else $error("out of range delay accepted");
  a_delay_hold: assert property (stmt_valid && state == ST_IDLE && stmt_op == seq_flow_pkg::OP_DELAY
    && delay_ms >= seq_flow_pkg::DELAY_MIN_MS && delay_ms <= seq_flow_pkg::DELAY_MAX_MS
    |=> stmt_busy && !flow_done)
    else $error("delay did not hold execution");
  a_loop_false: assert property (stmt_valid && state == ST_IDLE && stmt_op == seq_flow_pkg::OP_LOOP_BEGIN
    && cond_ok && !cond_true |=> flow_done && flow_next_pc == $past(stmt_match_pc) + 16'h1)
    else $error("false condition did not skip block");
  a_loop_return: assert property (stmt_valid && state == ST_IDLE && stmt_op == seq_flow_pkg::OP_LOOP_END
    && cl_found |=> flow_next_pc == $past(open_pc[cl_idx]))
    else $error("loop end did not return to start");
  a_break_exit: assert property (stmt_valid && state == ST_IDLE && stmt_op == seq_flow_pkg::OP_LOOP_BREAK
    && cl_found |=> flow_next_pc == $past(close_pc[cl_idx]) + 16'h1 && block_depth == $past(cl_idx))
    else $error("break did not exit loop");
  a_depth_cap: assert property (block_depth <= seq_flow_pkg::MAX_DEPTH)
    else $error("nesting deeper than six");
  a_paren_need: assert property (stmt_valid && state == ST_IDLE && stmt_op == seq_flow_pkg::OP_LOOP_BEGIN
    && !cond_paren_ok |=> flow_error)
    else $error("unparenthesised condition accepted");
  a_code_range: assert property (warn_code <= seq_flow_pkg::WARN_MAX)
    else $error("warning code beyond F2");
  a_clear_keeps: assert property (warning_clear_cmd && !warn_cond_active && !warn_take
    |=> warn_code == seq_flow_pkg::WARN_NONE && hist_flat == $past(hist_flat))
    else $error("clear failed or touched history");
  a_set_wins: assert property (warn_take |=> warn_code == $past(warn_code_in) && elapsed == 32'h0)
    else $error("warning lost against clear");
  a_report_snap: assert property (warning_status_query |=> report_valid
    && report_code == $past(warn_code) && report_elapsed_ms == $past(elapsed))
    else $error("query report wrong");
  a_pol_hold: assert property (pol_loaded && $past(pol_loaded) |-> $stable(polarity_active))
    else $error("polarity changed without reset");
  a_out_level: assert property (warning_output_assign
    == ((warn_code != seq_flow_pkg::WARN_NONE) ^ polarity_active))
    else $error("warning output level wrong");

  c_delay_done: cover property (stmt_busy ##1 !stmt_busy && flow_done);
  c_break: cover property (stmt_valid && stmt_op == seq_flow_pkg::OP_LOOP_BREAK && cl_found);
  c_full_depth: cover property (block_depth == seq_flow_pkg::MAX_DEPTH);
  c_set_clear: cover property (warn_take && warning_clear_cmd);
endmodule
`default_nettype wire

// ==== tb/nv_store_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Nonvolatile store for the saved output polarity; it has no reset, so a saved value outlives a device reset.
module nv_store_model (
  input  wire logic clk,
  input  wire logic polarity_write,
  input  wire logic polarity_value,
  output logic      polarity_stored
);
  initial polarity_stored = 1'h0;  // Factory value is normally open.
  // Each write is saved at once, but only reaches the active setting at the next reset.
  always @(posedge clk) begin
    if (polarity_write) begin
      polarity_stored <= polarity_value;
    end
  end
endmodule
`default_nettype wire

// ==== tb/sequence_flow_and_warning_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module sequence_flow_and_warning_unit_tb;
  logic clk = 0, rst_b = 0, stmt_valid = 0, cond_paren_ok = 1, warn_event = 0, warning_clear_cmd = 0;
  logic warning_status_query = 0, polarity_write = 0, polarity_value = 0, warn_cond_active = 0, polarity_stored;
  seq_flow_pkg::stmt_op_t stmt_op = seq_flow_pkg::OP_OTHER;
  seq_flow_pkg::cmp_op_t  cmp_op  = seq_flow_pkg::CMP_EQ;
  logic [15:0] stmt_pc = 0, stmt_match_pc = 0, flow_next_pc;
  logic [31:0] delay_ms = 0, report_elapsed_ms;
  logic signed [31:0] operand_a = 0, operand_b = 0;
  logic [7:0]  warn_code_in = 0, warn_code, report_code;
  logic [79:0] report_history;
  logic [2:0]  block_depth;
  logic stmt_busy, flow_done, flow_error, report_valid, polarity_active, polarity_pending;
  logic warning_signal_flag, warning_output_assign;
  int errors = 0, checked = 0, n;
  // A short tick keeps millisecond delays to a few cycles.
  sequence_flow_and_warning_unit #(.TICK_CYCLES(4)) DUT (.*);
  nv_store_model store (.clk(clk), .polarity_write(polarity_write), .polarity_value(polarity_value),
    .polarity_stored(polarity_stored));
  always #25 clk = ~clk;
  // Reset is held for 16 cycles; one more edge lets the saved polarity load.
  task automatic rs();
    rst_b <= 0;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    #1;
  endtask
  // One statement, valid for one edge; outputs are looked at once the answer edge has landed.
  task automatic st(input seq_flow_pkg::stmt_op_t o, input logic [15:0] p, m, input seq_flow_pkg::cmp_op_t c,
                    input logic signed [31:0] a, b, input logic k);
    @(posedge clk);
    stmt_valid <= 1; stmt_op <= o; stmt_pc <= p; stmt_match_pc <= m;
    cmp_op <= c; operand_a <= a; operand_b <= b; cond_paren_ok <= k;
    @(posedge clk);
    stmt_valid <= 0;
    #1;
  endtask
  // One pulse on the warning side inputs.
  task automatic w(input logic e, input logic [7:0] code, input logic cl, q, pw, pv);
    @(posedge clk);
    warn_event <= e; warn_code_in <= code; warning_clear_cmd <= cl;
    warning_status_query <= q; polarity_write <= pw; polarity_value <= pv;
    @(posedge clk);
    warn_event <= 0; warning_clear_cmd <= 0; warning_status_query <= 0; polarity_write <= 0;
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    rs();
    `CK("warn_code", 8'h00, warn_code)
    `CK("polarity_active", 1'h0, polarity_active)
    // A 2 ms delay must hold at least seven cycles before finishing.
    @(posedge clk);
    delay_ms <= 32'h0000_0002;
    st(seq_flow_pkg::OP_DELAY, 16'h0005, 0, seq_flow_pkg::CMP_EQ, 0, 0, 1);
    `CK("stmt_busy", 1'h1, stmt_busy)
    n = 0;
    while (flow_done !== 1'b1 && n < 200) begin @(posedge clk); #1; n++; end
    `CK("delay_long_enough", 1'h1, n >= 7)
    `CK("next_pc", 16'h0006, flow_next_pc)
    @(posedge clk);
    delay_ms <= 32'h0000_0000;
    st(seq_flow_pkg::OP_DELAY, 16'h0007, 0, seq_flow_pkg::CMP_EQ, 0, 0, 1);
    `CK("delay_zero", 1'h1, flow_error)
    $display("delay test done");
    // Every operator with 1 against 2; a true loop is left by a break.
    for (int i = 0; i < 6; i++) begin
      st(seq_flow_pkg::OP_LOOP_BEGIN, 16'h000A, 16'h0014, seq_flow_pkg::cmp_op_t'(i), 1, 2, 1);
      `CK("cond_pc", (i inside {1, 2, 3}) ? 16'h000B : 16'h0015, flow_next_pc)
      if (i inside {1, 2, 3}) begin
        st(seq_flow_pkg::OP_LOOP_BREAK, 16'h000C, 0, seq_flow_pkg::CMP_EQ, 0, 0, 1);
        `CK("break_pc", 16'h0015, flow_next_pc)
      end
      `CK("depth", 3'h0, block_depth)
    end
    // Loop end returns to the begin, which is evaluated anew and now fails.
    st(seq_flow_pkg::OP_LOOP_BEGIN, 16'h000A, 16'h0014, seq_flow_pkg::CMP_LT, 1, 2, 1);
    st(seq_flow_pkg::OP_LOOP_END, 16'h0014, 0, seq_flow_pkg::CMP_EQ, 0, 0, 1);
    `CK("end_pc", 16'h000A, flow_next_pc)
    st(seq_flow_pkg::OP_LOOP_BEGIN, 16'h000A, 16'h0014, seq_flow_pkg::CMP_GT, 1, 2, 1);
    `CK("reeval_depth", 3'h0, block_depth)
    // An end with no open loop breaks the pairing and must be refused.
    st(seq_flow_pkg::OP_LOOP_END, 16'h0016, 0, seq_flow_pkg::CMP_EQ, 0, 0, 1);
    `CK("unpaired_end", 1'h1, flow_error)
    st(seq_flow_pkg::OP_LOOP_BEGIN, 16'h000A, 16'h0014, seq_flow_pkg::CMP_LT, 1, 2, 0);
    `CK("no_paren", 1'h1, flow_error)
    st(seq_flow_pkg::OP_LOOP_BEGIN, 16'h000A, 16'h0014, seq_flow_pkg::CMP_LT, 32'h8000_0000, 2, 1);
    `CK("bad_operand", 1'h1, flow_error)
    // Six open blocks are allowed, the seventh is refused.
    for (int i = 0; i < 7; i++) st(seq_flow_pkg::OP_BLOCK_OPEN, 16'h0030, 16'h0040, seq_flow_pkg::CMP_EQ, 0, 0, 1);
    `CK("nest_error", 1'h1, flow_error)
    `CK("nest_depth", 3'h6, block_depth)
    $display("flow test done");
    w(1, 8'h22, 0, 0, 0, 0);
    `CK("warn_flag", 1'h1, warning_signal_flag & warning_output_assign)
    w(1, 8'hF3, 0, 0, 0, 0);
    `CK("code_range", 8'h22, warn_code)
    @(posedge clk);
    warn_cond_active <= 1;
    w(0, 0, 1, 0, 0, 0);
    `CK("clear_blocked", 8'h22, warn_code)
    @(posedge clk);
    warn_cond_active <= 0;
    w(0, 0, 1, 0, 0, 0);
    `CK("cleared", 8'h00, warn_code)
    w(0, 0, 0, 1, 0, 0);
    `CK("history", {1'h1, 8'h00, 8'h22}, {report_valid, report_code, report_history[7:0]})
    // Ten cycles of 4-cycle ticks separate the warning from the query.
    `CK("elapsed", 1'h1, report_elapsed_ms inside {32'h2, 32'h3})
    // A warning in the same cycle as a clear must win.
    w(1, 8'h23, 1, 0, 0, 0);
    `CK("set_wins", 8'h23, warn_code)
    w(0, 0, 0, 0, 1, 1);
    `CK("pol_pending", 2'h1, {polarity_active, polarity_pending})
    rs();
    `CK("pol_after_reset", 2'h3, {polarity_active, warning_output_assign})
    w(0, 0, 0, 1, 0, 0);
    `CK("history_lost", 80'h0, report_history)
    $display("warning test done");
    results();
  end
endmodule
`default_nettype wire
